// ==== bench/egress_queue_scheduler_shaper_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module egress_queue_scheduler_shaper_bench;
  import eqs_pkg::*;
  typedef struct packed {logic w; logic [13:0] a; logic [31:0] d;} row_t;
  logic clk, rst, cyc, stb, we, tick, pps, ack, txs, cut, gop, rdy, dn;
  logic [13:0] adr;
  logic [3:0] sel, pend;
  logic [31:0] dat, rdat, q;
  logic [1:0] qcnt, g, txq;
  logic [15:0] nb;
  logic [7:0] hold;
  int mismatches, n_tests, k, n;
  row_t rows [22] = '{
    '{0, 14'h2450, 32'h80}, '{0, 14'h2454, 32'h01},
    '{0, 14'h2458, 32'h534}, '{0, 14'h2460, 32'h5f2},
    '{0, 14'h2468, 32'h2000}, '{0, 14'h2480, 32'h0},
    '{0, 14'h248c, 32'h0}, '{1, 14'h2440, 32'h1},
    '{1, 14'h2454, 32'h7f}, '{0, 14'h2454, 32'h7f},
    '{1, 14'h2440, 32'h0}, '{0, 14'h2454, 32'h01},
    '{1, 14'h2450, 32'h50}, '{0, 14'h2450, 32'h90},
    '{1, 14'h2450, 32'h30}, '{0, 14'h2450, 32'h10},
    '{1, 14'h2450, 32'h80}, '{0, 14'h2000, 32'h0},
    '{1, 14'h248c, 32'h5}, '{1, 14'h2490, 32'h4000_0064},
    '{0, 14'h248c, 32'h5}, '{0, 14'h2490, 32'h4000_0064}};
  egress_queue_scheduler_shaper #(.SECOND_CYCLES(200)) DUT (
    .I_CLK_SYS(clk), .I_SRST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_QUEUE_COUNT(qcnt),
    .I_Q_PENDING(pend), .I_TX_READY(rdy), .I_TX_DONE(dn),
    .I_TX_BYTES(nb), .I_BYTE_TICK(tick), .I_PTP_PPS(pps),
    .O_TX_START(txs), .O_TX_QUEUE(txq), .O_TAS_CUT_THROUGH(cut),
    .O_GATE_OPEN(gop));
  eqs_mac_model mac (.i_clk(clk), .i_srst(rst), .i_start(txs),
    .i_hold(hold), .o_ready(rdy), .o_done(dn), .o_bytes(nb));
  always #5 clk = ~clk;
  always @(posedge clk) tick <= ~tick;
  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic wb(input logic w, input logic [13:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) begin
      mismatches++;
      tally_and_finish();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic grab(output logic [1:0] r);
    int t;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (txs !== 1'b1 && t < 300);
    if (t >= 300) begin
      mismatches++;
      tally_and_finish();
    end
    r = txq;
  endtask : grab
  // The list is rewritten with the engine stopped, so no half-written entry runs.
  task automatic gate_run(input logic [2:0] c, input logic [7:0] ctl,
                          input logic blk);
    int len, hits, t;
    pend <= 4'h0;
    wb(1'b1, 14'h2480, 32'h0, q);
    wb(1'b1, 14'h248c, 32'h0, q);
    wb(1'b1, 14'h2490, {c, 29'd10}, q);
    wb(1'b1, 14'h248c, 32'h1, q);
    wb(1'b1, 14'h2490, {EV_OPEN, 29'd40}, q);
    wb(1'b1, 14'h248c, 32'h2, q);
    wb(1'b1, 14'h2490, {EV_REPEAT, 29'd80}, q);
    wb(1'b1, 14'h2450, 32'ha0, q);
    pend <= 4'h1;
    wb(1'b1, 14'h2480, {24'h0, ctl}, q);
    `CHK(cut, ctl[7])
    len = 0;
    hits = 0;
    t = 0;
    while (gop !== 1'b0 && t < 300) begin
      @(posedge clk);
      t++;
    end
    while (gop === 1'b0 && len < 300) begin
      @(posedge clk);
      len++;
      if (len > 2 && txs === 1'b1 && gop === 1'b0) hits++;
    end
    `CHK(len, 30)
    `CHK(hits == 0, blk)
    t = 0;
    while (gop !== 1'b0 && t < 120) begin
      @(posedge clk);
      t++;
    end
    `CHK(t < 120, 1'b1)
    $display("gate run %h done", ctl);
  endtask : gate_run
  initial begin
    clk = 1'b0; rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; tick = 1'b0;
    pps = 1'b0; adr = 14'h0; sel = 4'h0; dat = 32'h0; qcnt = 2'h3;
    pend = 4'h0; hold = 8'h10; mismatches = 0; n_tests = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w) `CHK(q, rows[i].d)
    end
    $display("register table done");
    wb(1'b1, 14'h2450, 32'h00, q);
    repeat (20) @(posedge clk);
    pend <= 4'b1011;
    repeat (3) begin grab(g); `CHK(g, 2'h3) end
    $display("strict priority done");
    pend <= 4'h0;
    hold <= 8'h03;
    wb(1'b1, 14'h2450, 32'h80, q);
    wb(1'b1, 14'h2454, 32'h2, q);
    wb(1'b1, 14'h2440, 32'h1, q);
    wb(1'b1, 14'h2454, 32'h1, q);
    wb(1'b1, 14'h2440, 32'h0, q);
    repeat (20) @(posedge clk);
    pend <= 4'b0011;
    repeat (3) grab(g);
    k = 0;
    repeat (6) begin grab(g); if (g === 2'h0) k++; end
    `CHK(k, 4)
    $display("round robin done");
    pend <= 4'h0;
    qcnt <= 2'h0;
    repeat (20) @(posedge clk);
    pend <= 4'hf;
    repeat (4) begin grab(g); `CHK(g, 2'h0) end
    $display("single queue done");
    gate_run(EV_GUARD, 8'h83, 1'b1);
    gate_run(EV_CLOSED, 8'h03, 1'b0);
    gate_run(EV_CLOSED, 8'h43, 1'b1);
    wb(1'b1, 14'h2480, 32'h0, q);
    repeat (3) @(posedge clk);
    `CHK(gop, 1'b1)
    wb(1'b1, 14'h2480, 32'h2, q);
    repeat (30) @(posedge clk);
    `CHK(gop, 1'b1)
    pps <= 1'b1;
    @(posedge clk);
    pps <= 1'b0;
    n = 0;
    while (gop !== 1'b0 && n < 40) begin @(posedge clk); n++; end
    `CHK(n >= 10 && n <= 16, 1'b1)
    $display("pps origin done");
    wb(1'b1, 14'h2480, 32'h0, q);
    wb(1'b1, 14'h24a0, 32'hffff_ffff, q);
    wb(1'b1, 14'h2480, 32'h3, q);
    repeat (40) @(posedge clk);
    wb(1'b0, 14'h24b0, 32'h0, q);
    `CHK(q[8], 1'b0)
    wb(1'b1, 14'h2480, 32'h1, q);
    repeat (210) @(posedge clk);
    wb(1'b0, 14'h24b0, 32'h0, q);
    `CHK(q[8], 1'b1)
    $display("reference select done");
    pend <= 4'h0;
    repeat (20) @(posedge clk);
    wb(1'b1, 14'h2450, 32'h90, q);
    pend <= 4'h1;
    k = 0;
    repeat (300) begin @(posedge clk); if (txs === 1'b1) k++; end
    `CHK(k, 1)
    $display("credit shaper done");
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(gop, 1'b1)
    wb(1'b0, 14'h2454, 32'h0, q);
    `CHK(q, 32'h01)
    wb(1'b0, 14'h2450, 32'h0, q);
    `CHK(q, 32'h80)
    $display("second reset done");
    tally_and_finish();
  end
endmodule : egress_queue_scheduler_shaper_bench
`default_nettype wire

// ==== bench/eqs_mac_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module eqs_mac_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic [7:0] i_hold,
  output logic o_ready,
  output logic o_done,
  output logic [15:0] o_bytes
);
  logic [7:0] left;
  // One frame at a time, so ready stays low for the whole frame.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      left <= 8'h00;
    end else if (i_start) begin
      left <= i_hold;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign o_ready = (left == 8'h00) && !i_start;
  assign o_done = (left == 8'h01);
  // The length flips outside done so that a stale value is never trusted.
  assign o_bytes = o_done ? 16'h0040 : {15'h7fdf, left[0]};
endmodule : eqs_mac_model
`default_nettype wire

// ==== common/eqs_pkg.sv ====
package eqs_pkg;

  // Structure of the port.
  localparam int NUM_QUEUES = 4;
  localparam int QUEUE_W = 2;
  localparam int EVENT_DEPTH = 128;
  localparam int EVENT_INDEX_W = 7;
  localparam int EVENT_TIME_W = 29;

  // Timing of the internal one-second pulse.
  localparam int CLK_PERIOD_NS = 10;
  localparam int ONE_SECOND_NS = 1000000000;
  localparam int ONE_SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;

  // Register indices; the byte address of each is four times its index.
  localparam logic [11:0] IDX_QUEUE_SELECT = 12'h910;
  localparam logic [11:0] IDX_SCHED_SHAPER = 12'h914;
  localparam logic [11:0] IDX_RR_WEIGHT = 12'h915;
  localparam logic [11:0] IDX_CREDIT_HIGH = 12'h916;
  localparam logic [11:0] IDX_CREDIT_LOW = 12'h918;
  localparam logic [11:0] IDX_CREDIT_INC = 12'h91a;
  localparam logic [11:0] IDX_GATE_CTRL = 12'h920;
  localparam logic [11:0] IDX_EVENT_SELECT = 12'h923;
  localparam logic [11:0] IDX_EVENT_ENTRY = 12'h924;
  localparam logic [11:0] IDX_REF_TIME = 12'h928;
  localparam logic [11:0] IDX_GATE_STATUS = 12'h92c;

  // Field positions.
  localparam int SCHED_LSB = 6;
  localparam int SHAPER_LSB = 4;
  localparam int CUT_THROUGH_BIT = 7;
  localparam int RESTRICT_BIT = 6;
  localparam int REF_SEL_LSB = 0;

  // Values after reset.
  localparam logic [1:0] RST_SCHED = 2'h2;
  localparam logic [1:0] RST_SHAPER = 2'h0;
  localparam logic [6:0] RST_WEIGHT = 7'h01;
  localparam logic [15:0] RST_CREDIT_HIGH = 16'h0534;
  localparam logic [15:0] RST_CREDIT_LOW = 16'h05f2;
  localparam logic [15:0] RST_CREDIT_INC = 16'h2000;
  localparam logic [6:0] RST_EVENT_INDEX = 7'h00;

  // Field codes.
  localparam logic [1:0] SCHED_STRICT = 2'h0;
  localparam logic [1:0] SCHED_ROUND_ROBIN = 2'h2;
  localparam logic [1:0] SHAPE_NONE = 2'h0;
  localparam logic [1:0] SHAPE_CREDIT = 2'h1;
  localparam logic [1:0] SHAPE_GATE = 2'h2;
  localparam logic [1:0] SHAPE_RESERVED = 2'h3;
  localparam logic [1:0] REF_NONE = 2'h0;
  localparam logic [1:0] REF_FREE_RUN = 2'h1;
  localparam logic [1:0] REF_PPS = 2'h2;
  localparam logic [1:0] REF_AT_TIME = 2'h3;
  localparam logic [2:0] EV_CLOSED = 3'h0;
  localparam logic [2:0] EV_GUARD = 3'h1;
  localparam logic [2:0] EV_OPEN = 3'h2;
  localparam logic [2:0] EV_REPEAT = 3'h7;
  localparam logic [1:0] QCOUNT_ONE = 2'h0;
  localparam logic [1:0] QCOUNT_TWO = 2'h1;

  typedef enum logic [1:0] {
    GATE_CLOSED = 2'b00,
    GATE_OPEN = 2'b01,
    GATE_GUARD = 2'b11
  } gate_state_t;

  typedef struct packed {
    logic [1:0] sched;
    logic [1:0] shaper;
    logic [6:0] weight;
    logic [15:0] credit_hi;
    logic [15:0] credit_lo;
    logic [15:0] credit_inc;
  } queue_cfg_t;

  typedef struct packed {
    logic [2:0] code;
    logic [EVENT_TIME_W-1:0] at_cycle;
  } gate_event_t;

endpackage : eqs_pkg

// ==== rtl/egress_queue_scheduler_shaper.sv ====
// Summary of operation
// - Queue-indexed registers act on the selected queue.
// - Scheduler mode codes 01 and 11 are refused.
// - Strict priority always serves highest eligible queue.
// - Round robin serves each queue in turn.
// - Shaper field picks none, credit or gate.
// - Weight caps packets per round robin turn; zero acts as one.
// - Single-queue ports ignore weights entirely.
// - Credit high water mark per queue, 0x0534.
// - Credit low water mark per queue, 0x05f2.
// - Credit increment per queue, 0x2000 is 12.5%.
// - Cut-through enable bit, clear after reset.
// - Restricted gate traffic waits for open period.
// - Reference code 11 starts at time; 00 none.
// - Code 10 restarts on pps; 01 on second.
// - Event index selects the accessed list entry.
// - Event code: repeat, open, guard, closed.
// - Event time counts system clock cycles.
`timescale 1ns/10ps
`default_nettype none

module egress_queue_scheduler_shaper #(
  parameter int EVENT_ENTRIES = eqs_pkg::EVENT_DEPTH,
  parameter int SECOND_CYCLES = eqs_pkg::ONE_SECOND_CYCLES
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [13:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic [1:0] I_QUEUE_COUNT,
  input wire logic [eqs_pkg::NUM_QUEUES-1:0] I_Q_PENDING,
  input wire logic I_TX_READY,
  input wire logic I_TX_DONE,
  input wire logic [15:0] I_TX_BYTES,
  input wire logic I_BYTE_TICK,
  input wire logic I_PTP_PPS,
  output logic O_TX_START,
  output logic [eqs_pkg::QUEUE_W-1:0] O_TX_QUEUE,
  output logic O_TAS_CUT_THROUGH,
  output logic O_GATE_OPEN
);
  import eqs_pkg::*;

  localparam int AW = $clog2(EVENT_ENTRIES);
  localparam logic [EVENT_INDEX_W-1:0] EVENT_LAST = EVENT_INDEX_W'(EVENT_ENTRIES - 1);
  localparam logic [31:0] SECOND_LAST = 32'(SECOND_CYCLES - 1);

  if (EVENT_ENTRIES < 2 || EVENT_ENTRIES > (1 << EVENT_INDEX_W) ||
      (EVENT_ENTRIES & (EVENT_ENTRIES - 1)) != 0 || SECOND_CYCLES < 2) begin : g_bad_params
    $error("Unsupported event list depth or second length");
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SRST);

  logic [11:0] bus_idx;
  logic req;
  logic wr;
  logic [31:0] wd;
  logic [31:0] merged;
  logic [31:0] next_rdata;
  logic [QUEUE_W-1:0] queue_sel;
  queue_cfg_t cfg [NUM_QUEUES];
  logic restricted;
  logic [1:0] ref_sel;
  logic [EVENT_INDEX_W-1:0] event_sel;
  logic [31:0] ref_time;
  logic [31:0] bus_ev;
  logic [31:0] eng_raw;
  gate_event_t eng_ev;
  logic [NUM_QUEUES-1:0] active;
  logic [NUM_QUEUES-1:0] elig;
  logic single;
  logic tx_busy;
  logic grant;
  logic pick_valid;
  logic [QUEUE_W-1:0] next_pick;
  logic [QUEUE_W-1:0] rr_q;
  logic [6:0] rr_cnt;
  logic [6:0] next_rr_cnt;
  gate_state_t gate;
  logic running;
  logic fetch_ok;
  logic fire;
  logic [EVENT_TIME_W-1:0] elapsed;
  logic [EVENT_INDEX_W-1:0] eng_idx;
  logic [EVENT_INDEX_W-1:0] next_idx;
  logic [31:0] sec_cnt;
  logic sec_tick;
  logic [31:0] now;
  logic armed;
  logic origin_start;
  logic wr_ctrl;

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] neu,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = neu[8*i +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // A request is answered one cycle after it is seen; the ack itself blocks a second take.
  assign bus_idx = I_WB_ADR[13:2];
  assign req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wr = req && I_WB_WE;
  assign wd = I_WB_DAT;
  assign wr_ctrl = wr && bus_idx == IDX_GATE_CTRL && I_WB_SEL[0];

  always_comb begin
    merged = 32'h0;
    unique case (bus_idx)
      IDX_CREDIT_HIGH: merged = lane_merge({16'h0, cfg[queue_sel].credit_hi}, wd, I_WB_SEL);
      IDX_CREDIT_LOW: merged = lane_merge({16'h0, cfg[queue_sel].credit_lo}, wd, I_WB_SEL);
      IDX_CREDIT_INC: merged = lane_merge({16'h0, cfg[queue_sel].credit_inc}, wd, I_WB_SEL);
      default: merged = lane_merge(ref_time, wd, I_WB_SEL);
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      queue_sel <= '0;
      for (int q = 0; q < NUM_QUEUES; q++) begin
        cfg[q] <= '{RST_SCHED, RST_SHAPER, RST_WEIGHT, RST_CREDIT_HIGH, RST_CREDIT_LOW,
                    RST_CREDIT_INC};
      end
      O_TAS_CUT_THROUGH <= 1'b0;
      restricted <= 1'b0;
      ref_sel <= REF_NONE;
      event_sel <= RST_EVENT_INDEX;
      ref_time <= 32'h0;
    end else if (wr) begin
      unique case (bus_idx)
        IDX_QUEUE_SELECT: if (I_WB_SEL[0]) queue_sel <= wd[QUEUE_W-1:0];
        IDX_SCHED_SHAPER: begin
          if (I_WB_SEL[0] && !wd[SCHED_LSB]) cfg[queue_sel].sched <= wd[SCHED_LSB +: 2];
          if (I_WB_SEL[0] && wd[SHAPER_LSB +: 2] != SHAPE_RESERVED) begin
            cfg[queue_sel].shaper <= wd[SHAPER_LSB +: 2];
          end
        end
        IDX_RR_WEIGHT: if (I_WB_SEL[0]) cfg[queue_sel].weight <= wd[6:0];
        IDX_CREDIT_HIGH: cfg[queue_sel].credit_hi <= merged[15:0];
        IDX_CREDIT_LOW: cfg[queue_sel].credit_lo <= merged[15:0];
        IDX_CREDIT_INC: cfg[queue_sel].credit_inc <= merged[15:0];
        IDX_GATE_CTRL: begin
          if (I_WB_SEL[0]) begin
            O_TAS_CUT_THROUGH <= wd[CUT_THROUGH_BIT];
            restricted <= wd[RESTRICT_BIT];
            ref_sel <= wd[REF_SEL_LSB +: 2];
          end
        end
        IDX_EVENT_SELECT: if (I_WB_SEL[0]) event_sel <= wd[EVENT_INDEX_W-1:0];
        IDX_REF_TIME: ref_time <= merged;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    unique case (bus_idx)
      IDX_QUEUE_SELECT: next_rdata = {30'h0, queue_sel};
      IDX_SCHED_SHAPER: next_rdata = {24'h0, cfg[queue_sel].sched, cfg[queue_sel].shaper, 4'h0};
      IDX_RR_WEIGHT: next_rdata = {25'h0, cfg[queue_sel].weight};
      IDX_CREDIT_HIGH: next_rdata = {16'h0, cfg[queue_sel].credit_hi};
      IDX_CREDIT_LOW: next_rdata = {16'h0, cfg[queue_sel].credit_lo};
      IDX_CREDIT_INC: next_rdata = {16'h0, cfg[queue_sel].credit_inc};
      IDX_GATE_CTRL: next_rdata = {24'h0, O_TAS_CUT_THROUGH, restricted, 4'h0, ref_sel};
      IDX_EVENT_SELECT: next_rdata = {25'h0, event_sel};
      IDX_EVENT_ENTRY: next_rdata = bus_ev;
      IDX_REF_TIME: next_rdata = ref_time;
      IDX_GATE_STATUS: next_rdata = {20'h0, gate, 1'b0, running, 1'b0, eng_idx};
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
    end else begin
      O_WB_ACK <= req;
      if (req) begin
        O_WB_DAT <= next_rdata;
      end
    end
  end

  a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("Ack held too long");

  // A partial write would leave half an event in the list, so only whole words are taken.
  gate_event_mem #(
    .DEPTH(EVENT_ENTRIES),
    .WIDTH(32)
  ) u_event_mem (
    .i_clk(I_CLK_SYS),
    .i_wr_en(wr && bus_idx == IDX_EVENT_ENTRY && I_WB_SEL == 4'hf),
    .i_wr_addr(event_sel[AW-1:0]),
    .i_wr_data(wd),
    .i_rd_a_addr(event_sel[AW-1:0]),
    .o_rd_a_data(bus_ev),
    .i_rd_b_addr(eng_idx[AW-1:0]),
    .o_rd_b_data(eng_raw)
  );
  assign eng_ev = gate_event_t'(eng_raw);

  always_comb begin
    single = I_QUEUE_COUNT == QCOUNT_ONE;
    unique case (I_QUEUE_COUNT)
      QCOUNT_ONE: active = 4'h1;
      QCOUNT_TWO: active = 4'h3;
      default: active = 4'hf;
    endcase
  end

  for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_queue
    logic signed [17:0] credit;
    logic signed [18:0] wide;
    logic [15:0] frac;
    logic [16:0] frac_sum;
    logic sent_here;
    logic gate_ok;

    assign sent_here = I_TX_DONE && tx_busy && O_TX_QUEUE == QUEUE_W'(q);
    assign frac_sum = {1'b0, frac} + {1'b0, cfg[q].credit_inc};

    // Credit grows by the increment share of each byte time and is clamped to the marks.
    always_comb begin
      wide = {credit[17], credit};
      if (I_BYTE_TICK && frac_sum[16]) begin
        wide = wide + 19'sh1;
      end
      if (sent_here) begin
        wide = wide - $signed({3'h0, I_TX_BYTES});
      end
      if (wide > $signed({3'h0, cfg[q].credit_hi})) begin
        wide = $signed({3'h0, cfg[q].credit_hi});
      end
      if (wide < -$signed({3'h0, cfg[q].credit_lo})) begin
        wide = -$signed({3'h0, cfg[q].credit_lo});
      end
    end

    always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST || cfg[q].shaper != SHAPE_CREDIT) begin
        credit <= 18'sh0;
        frac <= 16'h0;
      end else begin
        credit <= wide[17:0];
        if (I_BYTE_TICK) begin
          frac <= frac_sum[15:0];
        end
      end
    end

    assign gate_ok = gate != GATE_GUARD && (!restricted || gate == GATE_OPEN);
    assign elig[q] = active[q] && I_Q_PENDING[q] &&
                     (cfg[q].shaper != SHAPE_CREDIT || !credit[17]) &&
                     (cfg[q].shaper != SHAPE_GATE || gate_ok);

    a_credit_ceiling: assert property (credit <= $signed({2'h0, $past(cfg[q].credit_hi)}))
      else $error("Credit above high water mark");
  end

  // The policy is a port property; queue 0 carries the field that steers it.
  always_comb begin
    pick_valid = 1'b0;
    next_pick = '0;
    next_rr_cnt = rr_cnt;
    if (single) begin
      pick_valid = elig[0];
    end else if (cfg[0].sched == SCHED_STRICT) begin
      for (int i = 0; i < NUM_QUEUES; i++) begin
        if (elig[i]) begin
          pick_valid = 1'b1;
          next_pick = QUEUE_W'(i);
        end
      end
    end else if (elig[rr_q] && rr_cnt < cfg[rr_q].weight) begin
      pick_valid = 1'b1;
      next_pick = rr_q;
      next_rr_cnt = rr_cnt + 7'h01;
    end else begin
      for (int k = 1; k <= NUM_QUEUES; k++) begin
        if (!pick_valid && elig[rr_q + QUEUE_W'(k)]) begin
          pick_valid = 1'b1;
          next_pick = rr_q + QUEUE_W'(k);
          next_rr_cnt = 7'h01;
        end
      end
    end
  end

  assign grant = !tx_busy && I_TX_READY && pick_valid;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_TX_START <= 1'b0;
      O_TX_QUEUE <= '0;
      tx_busy <= 1'b0;
    end else begin
      O_TX_START <= grant;
      if (grant) begin
        O_TX_QUEUE <= next_pick;
        tx_busy <= 1'b1;
      end else if (I_TX_DONE) begin
        tx_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      rr_q <= '0;
      rr_cnt <= 7'h00;
    end else if (grant && !single) begin
      rr_q <= next_pick;
      rr_cnt <= next_rr_cnt;
    end
  end

  a_strict_order: assert property ((grant && !single && cfg[0].sched == SCHED_STRICT) |=>
    (O_TX_START && (($past(elig) >> O_TX_QUEUE) >> 1) == '0))
    else $error("Strict priority skipped a higher queue");
  a_single_queue: assert property ((grant && single) |=> (O_TX_START && O_TX_QUEUE == '0))
    else $error("Single-queue port sent from another queue");
  a_rr_budget: assert property ((grant && !single && cfg[0].sched == SCHED_ROUND_ROBIN &&
    cfg[next_pick].weight != 7'h00) |=> (rr_cnt <= $past(cfg[next_pick].weight)))
    else $error("Round robin exceeded queue weight");
  a_guard_hold: assert property (grant |->
    !(cfg[next_pick].shaper == SHAPE_GATE && gate == GATE_GUARD))
    else $error("Gated frame started in guard band");
  a_restricted_open: assert property ((grant && restricted &&
    cfg[next_pick].shaper == SHAPE_GATE) |-> gate == GATE_OPEN)
    else $error("Restricted gated frame outside open period");
  a_sched_reserved: assert property ((wr && bus_idx == IDX_SCHED_SHAPER && I_WB_SEL[0] &&
    wd[SCHED_LSB]) |=> cfg[$past(queue_sel)].sched == $past(cfg[queue_sel].sched))
    else $error("Reserved scheduler code was stored");

  // Internal second pulse and free-running cycle count used as the reference time base.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || sec_tick) begin
      sec_cnt <= 32'h0;
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
    end
  end
  assign sec_tick = sec_cnt == SECOND_LAST;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      now <= 32'h0;
    end else begin
      now <= now + 32'h1;
    end
  end

  // Writing code 11 arms a single start; an arm in the start cycle wins over the disarm.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      armed <= 1'b0;
    end else if (wr_ctrl && wd[REF_SEL_LSB +: 2] == REF_AT_TIME) begin
      armed <= 1'b1;
    end else if (origin_start) begin
      armed <= 1'b0;
    end
  end

  always_comb begin
    unique case (ref_sel)
      REF_FREE_RUN: origin_start = sec_tick;
      REF_PPS: origin_start = I_PTP_PPS;
      REF_AT_TIME: origin_start = armed && now >= ref_time;
      default: origin_start = 1'b0;
    endcase
  end

  assign fire = running && fetch_ok && elapsed >= eng_ev.at_cycle;
  assign next_idx = (eng_idx == EVENT_LAST) ? '0 : eng_idx + 7'h01;

  // The list memory answers one cycle late, so each new index waits one cycle before it fires.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || ref_sel == REF_NONE) begin
      running <= 1'b0;
      elapsed <= '0;
      eng_idx <= '0;
      fetch_ok <= 1'b0;
      gate <= GATE_OPEN;
    end else if (origin_start) begin
      running <= 1'b1;
      elapsed <= '0;
      eng_idx <= '0;
      fetch_ok <= 1'b0;
    end else if (running) begin
      fetch_ok <= !fire;
      if (elapsed != '1) begin
        elapsed <= elapsed + 29'h1;
      end
      if (fire) begin
        if (eng_ev.code == EV_REPEAT) begin
          elapsed <= '0;
          eng_idx <= '0;
        end else begin
          eng_idx <= next_idx;
          if (eng_ev.code == EV_OPEN) gate <= GATE_OPEN;
          if (eng_ev.code == EV_GUARD) gate <= GATE_GUARD;
          // A close inside a guard band keeps the band, so no gated frame starts before open.
          if (eng_ev.code == EV_CLOSED && gate != GATE_GUARD) gate <= GATE_CLOSED;
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_GATE_OPEN <= 1'b1;
    end else begin
      O_GATE_OPEN <= gate == GATE_OPEN;
    end
  end

  sequence s_fire_quiet;
    fire && !origin_start && !wr_ctrl && ref_sel != REF_NONE;
  endsequence
  sequence s_fire_repeat;
    s_fire_quiet ##0 eng_ev.code == EV_REPEAT;
  endsequence
  sequence s_fire_step;
    s_fire_quiet ##0 eng_ev.code != EV_REPEAT;
  endsequence

  a_repeat_restart: assert property (s_fire_repeat |=> (eng_idx == '0 && elapsed == '0))
    else $error("Repeat event did not restart the list");
  a_event_step: assert property (s_fire_step |=>
    eng_idx == (($past(eng_idx) == EVENT_LAST) ? '0 : $past(eng_idx) + 7'h01))
    else $error("Event list did not advance by one");
  a_guard_entry: assert property ((s_fire_step ##0 eng_ev.code == EV_GUARD) |=>
    (gate == GATE_GUARD ##1 !O_GATE_OPEN))
    else $error("Guard event did not enter guard band");
  a_pps_origin: assert property ((ref_sel == REF_PPS && I_PTP_PPS && !wr_ctrl) |=>
    (running && elapsed == '0 && eng_idx == '0))
    else $error("Pps did not restart the cycle origin");

endmodule : egress_queue_scheduler_shaper

`default_nettype wire

// ==== rtl/gate_event_mem.sv ====
`timescale 1ns/10ps
`default_nettype none

module gate_event_mem #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 32
) (
  input wire logic i_clk,
  input wire logic i_wr_en,
  input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic [$clog2(DEPTH)-1:0] i_rd_a_addr,
  output logic [WIDTH-1:0] o_rd_a_data,
  input wire logic [$clog2(DEPTH)-1:0] i_rd_b_addr,
  output logic [WIDTH-1:0] o_rd_b_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Entries power up unknown; software must fill the list before use.
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rd_a_data <= mem[i_rd_a_addr];
    o_rd_b_data <= mem[i_rd_b_addr];
  end

endmodule : gate_event_mem

`default_nettype wire
